/* verilog/swr_pkg.sv */
// Shared constants and types for the seconds counter / watchdog clock.
// Assumes one system clock; every pin arrives asynchronous to it.
package swr_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] REG_SECS_B0 = 4'h0;
   localparam logic [3:0] REG_SECS_B3 = 4'h3;
   localparam logic [3:0] REG_CDN_B0 = 4'h4;
   localparam logic [3:0] REG_CDN_B2 = 4'h6;
   localparam logic [3:0] REG_CONTROL = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_LAST = 4'h8;
   // ****************************************
   // Control and status fields
   // ****************************************
   localparam int CTL_OSC_STOP = 7;
   localparam int CTL_CDN_EN = 6;
   localparam int CTL_MODE_SEL = 5;
   localparam int CTL_OUT_SEL = 3;
   localparam int CTL_RATE_HI = 2;
   localparam int CTL_RATE_LO = 1;
   localparam int CTL_IRQ_EN = 0;
   localparam logic [7:0] CTL_WR_MASK = 8'hef;
   localparam logic [7:0] CTL_RESET = 8'h06;
   localparam int STS_OSC_FLAG = 7;
   localparam int STS_ALARM_FLAG = 0;
   localparam logic STS_OSC_RESET = 1'b1;
   // ****************************************
   // Time base
   // ****************************************
   localparam int OSC_HZ = 32768;
   localparam int PULSE_MS = 250;
   localparam int PULSE_TICKS = OSC_HZ * PULSE_MS / 1000;
   localparam logic [14:0] CHAIN_WRAP = 15'h7fff;
   localparam logic [2:0] FAST_WRAP = 3'h7;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
   // ****************************************
   // Serial engine states
   // ****************************************
   typedef enum logic [6:0] {
      SW_IDLE = 7'h01,
      SW_DEV_ADDR = 7'h02,
      SW_ADDR_ACK = 7'h04,
      SW_RX_BYTE = 7'h08,
      SW_RX_ACK = 7'h10,
      SW_TX_BYTE = 7'h20,
      SW_TX_ACK = 7'h40
   } swr_serial_e;
   // Pin synchroniser: two stages plus an edge-detect copy
   typedef struct packed {
      logic s1;
      logic s2;
      logic q;
   } swr_sync_s;
   // Whole state of the block
   typedef struct packed {
      swr_sync_s scl;
      swr_sync_s sda;
      swr_sync_s xtal;
      swr_sync_s watchdog_strobe_in;
      swr_serial_e state;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic rw;
      logic ptrLoad;
      logic [3:0] ptr;
      logic sdaLow;
      logic [31:0] secs;
      logic [31:0] shadow;
      logic [23:0] cnt;
      logic [23:0] seed;
      logic [7:0] ctrl;
      logic osc_stopped_flag;
      logic af;
      logic [14:0] todChain;
      logic [14:0] wdChain;
      logic [15:0] pulseCnt;
      logic irqLow;
   } swr_state_s;
endpackage

/* verilog/swr_core.sv */
// Seconds counter with countdown watchdog/alarm, two-wire register access.
// Assumes a 250 MHz clock; crystal, strobe and bus pins are asynchronous.
// Notes on behaviour
// [R1] Rising strobe edge reloads countdown from seed and restarts its chain.
// [R2] A steady strobe level leaves the countdown decrementing normally.
// [R3] Pointer steps after each byte, wrapping from 08h to 00h.
// [R4] START, STOP and pointer wrap to 00h copy seconds into the shadow.
// [R5] Seconds reads return the shadow while the live count runs on.
// [R6] Thirty-two bit seconds counter counts up from a written value.
// [R7] Twenty-four bit countdown works as watchdog or alarm.
// [R8] Seconds bytes sit least significant first at 00h to 03h.
// [R9] Countdown bytes sit least significant first at 04h to 06h.
// [R10] Shared output only pulls low; carries square wave or alarm interrupt.
// [R11] Only documented defaults are set; other contents start at zero.
// [R12] Registers are reached only over the two-wire bus, host clocks.
// [R13] All time bases come from the 32.768kHz crystal input.
// [R14] Control and status bit layout as mapped at 07h and 08h.
// [R15] Countdown writes load counter and seed; reloads use the seed.
// [R16] Mode 0: decrement per second, flag at zero, reload and restart.
// [R17] Mode 1: 1/4096 s steps, stop at zero, untruncated 250ms low pulse.
// [R18] Software clears the alarm flag by writing 0; writing 1 does nothing.
`timescale 1ns/100ps
module swr_core import swr_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
   parameter int PULSE_LEN = PULSE_TICKS
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic crystalIn,
   input wire logic watchdogStrobeIn,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOen,
   output logic waveOrIrqOut,
   output logic waveOrIrqOen
);
   // ****************************************
   // State and event terms
   // ****************************************
   swr_state_s st_r;
   swr_state_s st_nxt;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   logic oscTick;
   logic wdTick;
   logic wdsRise;
   logic afSet;
   logic wrEn;
   logic [3:0] wrAddr;
   logic [7:0] wrData;
   logic cdnRead;
   logic [7:0] rdData;
   logic [3:0] ptrInc;
   logic waveBit;

   // ****************************************
   // Register read mux, seconds from the shadow copy
   // ****************************************
   function automatic logic [7:0] rd_byte(input swr_state_s s, input logic [3:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a <= REG_SECS_B3) begin
         d = s.shadow[8*a[1:0] +: 8]; // R5 R8
      end else if (a <= REG_CDN_B2) begin
         d = s.cnt[8*(a - REG_CDN_B0) +: 8]; // R9
      end else if (a == REG_CONTROL) begin
         d = s.ctrl & CTL_WR_MASK; // R14
      end else if (a == REG_STATUS) begin
         d[STS_OSC_FLAG] = s.osc_stopped_flag; // R14
         d[STS_ALARM_FLAG] = s.af;
      end
      return d;
   endfunction

   // ****************************************
   // Pin outputs: open-drain, enable low while pulling low
   // ****************************************
   // Data tied low, so a pin never fights its pull-up
   assign sdaOut = 1'b0;
   assign sdaOen = ~st_r.sdaLow; // R12
   assign waveOrIrqOut = 1'b0;
   assign waveOrIrqOen = ~st_r.irqLow; // R10

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      afSet = 1'b0;
      wrEn = 1'b0;
      wrAddr = st_r.ptr;
      wrData = st_r.shift;
      cdnRead = 1'b0;
      rdData = rd_byte(st_r, st_r.ptr);
      ptrInc = (st_r.ptr >= REG_LAST) ? REG_SECS_B0 : st_r.ptr + 4'h1; // R3
      // ****************************************
      // Synchronisers, two flops before any use
      // ****************************************
      st_nxt.scl = '{sclIn, st_r.scl.s1, st_r.scl.s2};
      st_nxt.sda = '{sdaIn, st_r.sda.s1, st_r.sda.s2};
      st_nxt.xtal = '{crystalIn, st_r.xtal.s1, st_r.xtal.s2};
      st_nxt.watchdog_strobe_in = '{watchdogStrobeIn, st_r.watchdog_strobe_in.s1, st_r.watchdog_strobe_in.s2};
      sclRise = st_r.scl.s2 & ~st_r.scl.q;
      sclFall = ~st_r.scl.s2 & st_r.scl.q;
      startEv = st_r.scl.s2 & st_r.scl.q & ~st_r.sda.s2 & st_r.sda.q;
      stopEv = st_r.scl.s2 & st_r.scl.q & st_r.sda.s2 & ~st_r.sda.q;
      wdsRise = st_r.watchdog_strobe_in.s2 & ~st_r.watchdog_strobe_in.q;
      oscTick = st_r.xtal.s2 & ~st_r.xtal.q & ~st_r.ctrl[CTL_OSC_STOP]; // R13

      // ****************************************
      // Two-wire slave engine
      // ****************************************
      // START and STOP win over any state, so a cut frame recovers
      if (startEv || stopEv) begin
         st_nxt.state = startEv ? SW_DEV_ADDR : SW_IDLE;
         st_nxt.bitCnt = 4'h0;
         st_nxt.sdaLow = 1'b0;
         st_nxt.shadow = st_r.secs; // R4
      end else begin
         case (st_r.state)
            SW_DEV_ADDR, SW_RX_BYTE: begin
               if (sclRise) begin
                  st_nxt.shift = {st_r.shift[6:0], st_r.sda.s2};
                  st_nxt.bitCnt = st_r.bitCnt + 4'h1;
               end else if (sclFall && st_r.bitCnt == 4'h8) begin
                  st_nxt.sdaLow = 1'b1;
                  if (st_r.state == SW_RX_BYTE) begin
                     st_nxt.state = SW_RX_ACK;
                     if (st_r.ptrLoad) begin
                        st_nxt.ptr = st_r.shift[3:0];
                        st_nxt.ptrLoad = 1'b0;
                     end else begin
                        wrEn = 1'b1;
                        st_nxt.ptr = ptrInc; // R3
                        if (ptrInc == REG_SECS_B0) begin
                           st_nxt.shadow = st_r.secs; // R4
                        end
                     end
                  end else if (st_r.shift[7:1] == DEV_ADDR) begin
                     st_nxt.state = SW_ADDR_ACK;
                     st_nxt.rw = st_r.shift[0];
                     st_nxt.ptrLoad = ~st_r.shift[0];
                  end else begin
                     st_nxt.state = SW_IDLE;
                     st_nxt.sdaLow = 1'b0;
                  end
               end
            end
            SW_ADDR_ACK, SW_RX_ACK, SW_TX_ACK: begin
               if (sclRise && st_r.state == SW_TX_ACK && st_r.sda.s2) begin
                  st_nxt.state = SW_IDLE; // Master ended the read
               end else if (sclFall) begin
                  st_nxt.bitCnt = 4'h0;
                  st_nxt.sdaLow = 1'b0;
                  if (st_r.state == SW_RX_ACK || !st_r.rw) begin
                     st_nxt.state = SW_RX_BYTE;
                  end else begin
                     st_nxt.state = SW_TX_BYTE;
                     st_nxt.shift = rdData;
                     st_nxt.sdaLow = ~rdData[7];
                     cdnRead = (st_r.ptr >= REG_CDN_B0) && (st_r.ptr <= REG_CDN_B2);
                  end
               end
            end
            SW_TX_BYTE: begin
               if (sclFall) begin
                  if (st_r.bitCnt == 4'h7) begin
                     st_nxt.state = SW_TX_ACK;
                     st_nxt.sdaLow = 1'b0;
                     st_nxt.ptr = ptrInc; // R3
                     if (ptrInc == REG_SECS_B0) begin
                        st_nxt.shadow = st_r.secs; // R4
                     end
                  end else begin
                     st_nxt.shift = {st_r.shift[6:0], 1'b0};
                     st_nxt.sdaLow = ~st_r.shift[6];
                     st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                  end
               end
            end
            default: begin
               st_nxt.state = SW_IDLE;
               st_nxt.sdaLow = 1'b0;
            end
         endcase
      end

      // ****************************************
      // Seconds chain and counter
      // ****************************************
      if (oscTick) begin
         st_nxt.todChain = st_r.todChain + 15'h0001;
         if (st_r.todChain == CHAIN_WRAP) begin
            st_nxt.secs = st_r.secs + 32'h00000001; // R6
         end
      end

      // ****************************************
      // Countdown chain and counter; strobe level alone changes nothing
      // ****************************************
      wdTick = 1'b0;
      if (oscTick) begin
         st_nxt.wdChain = st_r.wdChain + 15'h0001;
         if (st_r.ctrl[CTL_MODE_SEL]) begin
            wdTick = (st_r.wdChain[2:0] == FAST_WRAP); // R17
         end else begin
            wdTick = (st_r.wdChain == CHAIN_WRAP); // R16
         end
      end
      if (st_r.ctrl[CTL_CDN_EN] && wdTick && st_r.cnt != 24'h000000) begin // R2 R7
         if (st_r.cnt == 24'h000001) begin
            afSet = 1'b1;
            st_nxt.cnt = st_r.ctrl[CTL_MODE_SEL] ? 24'h000000 : st_r.seed; // R16 R17
         end else begin
            st_nxt.cnt = st_r.cnt - 24'h000001;
         end
      end

      // ****************************************
      // Register writes take priority over counting
      // ****************************************
      // A write and a count step in one cycle keep the written byte
      if (wrEn) begin
         if (wrAddr <= REG_SECS_B3) begin
            st_nxt.secs[8*wrAddr[1:0] +: 8] = wrData; // R6 R8
            st_nxt.todChain[14:3] = 12'h000;
         end else if (wrAddr <= REG_CDN_B2) begin
            st_nxt.cnt[8*(wrAddr - REG_CDN_B0) +: 8] = wrData; // R15
            st_nxt.seed[8*(wrAddr - REG_CDN_B0) +: 8] = wrData;
            st_nxt.wdChain = 15'h0000;
         end else if (wrAddr == REG_CONTROL) begin
            st_nxt.ctrl = wrData & CTL_WR_MASK; // R14
         end else if (wrAddr == REG_STATUS) begin
            if (!wrData[STS_OSC_FLAG]) begin
               st_nxt.osc_stopped_flag = 1'b0;
            end
            if (!wrData[STS_ALARM_FLAG]) begin
               st_nxt.af = 1'b0; // R18
            end
         end
      end

      // ****************************************
      // Reload from seed on strobe edge or on a watchdog-mode countdown read while the strobe is low
      // ****************************************
      if (st_r.ctrl[CTL_CDN_EN] && (wdsRise ||
          (cdnRead && st_r.ctrl[CTL_MODE_SEL] && !st_r.watchdog_strobe_in.s2))) begin
         st_nxt.cnt = st_r.seed; // R1 R15
         st_nxt.wdChain = 15'h0000;
      end

      // ****************************************
      // Alarm pulse in watchdog mode, not cut short by software
      // ****************************************
      // Flag writes cannot shorten it; only the tick count ends it
      if (st_r.pulseCnt != 16'h0000 && oscTick) begin
         st_nxt.pulseCnt = st_r.pulseCnt - 16'h0001; // R17
         if (st_r.pulseCnt == 16'h0001) begin
            st_nxt.af = 1'b0;
         end
      end
      if (afSet) begin
         st_nxt.af = 1'b1; // R18
         if (st_r.ctrl[CTL_MODE_SEL] && st_r.ctrl[CTL_IRQ_EN] && st_r.ctrl[CTL_OUT_SEL]) begin
            st_nxt.pulseCnt = PULSE_LEN[15:0]; // R17
         end
      end
      if (st_r.ctrl[CTL_OSC_STOP]) begin
         st_nxt.osc_stopped_flag = 1'b1; // R14
      end

      // ****************************************
      // Output select: square wave or interrupt
      // ****************************************
      case ({st_r.ctrl[CTL_RATE_HI], st_r.ctrl[CTL_RATE_LO]})
         2'b00: waveBit = st_r.todChain[14];
         2'b01: waveBit = st_r.todChain[2];
         2'b10: waveBit = st_r.todChain[1];
         default: waveBit = st_r.xtal.q;
      endcase
      if (st_r.ctrl[CTL_OUT_SEL]) begin
         st_nxt.irqLow = (st_r.af && st_r.ctrl[CTL_IRQ_EN] && !st_r.ctrl[CTL_MODE_SEL])
            || (st_r.pulseCnt != 16'h0000); // R10
      end else begin
         st_nxt.irqLow = !st_r.ctrl[CTL_OSC_STOP] && !waveBit; // R10
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Synchronous reset; pins start released
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st_r <= '0; // R11
         // Bus lines idle high, so no false START after reset
         st_r.scl <= '1;
         st_r.sda <= '1;
         st_r.state <= SW_IDLE;
         st_r.ctrl <= CTL_RESET; // R14
         st_r.osc_stopped_flag <= STS_OSC_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // swr_core

/* sim/swr_core_properties.sv */
// Checker for the two-wire port and the shared output pin of the core.
// Sees only the core ports; bound into every core instance below.
`timescale 1ns/100ps
module swr_core_properties import swr_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
   parameter int PULSE_LEN = PULSE_TICKS
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic crystalIn,
   input wire logic watchdogStrobeIn,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOen,
   input wire logic waveOrIrqOut,
   input wire logic waveOrIrqOen
);
   // ****************************************
   // Bus event decode
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [3:0] bitCnt_r;
   logic [7:0] addrSh_r;
   logic sclD_r;
   logic sdaD_r;
   wire startEv = sclIn && sclD_r && sdaD_r && !sdaIn;
   wire stopEv = sclIn && sclD_r && !sdaD_r && sdaIn;
   wire sclFall = sclD_r && !sclIn;
   // Count bits of the first byte after a start
   always_ff @(posedge clock) begin
      sclD_r <= sclIn;
      sdaD_r <= sdaIn;
      if (!resetn || startEv) begin
         bitCnt_r <= resetn ? 4'h0 : 4'h9;
      end else if (sclIn && !sclD_r && bitCnt_r < 4'h9) begin
         bitCnt_r <= bitCnt_r + 4'h1;
         addrSh_r <= {addrSh_r[6:0], sdaIn};
      end
   end
   sequence ackMatch;
      sclFall && bitCnt_r == 4'h8 && addrSh_r[7:1] == DEV_ADDR;
   endsequence
   sequence ackMiss;
      sclFall && bitCnt_r == 4'h8 && addrSh_r[7:1] != DEV_ADDR;
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   a_sda_drive_zero: assert property (!sdaOut)
      else $error("data pin drives a high level");
   a_irq_drive_zero: assert property (!waveOrIrqOut)
      else $error("shared output drives a high level");
   a_reset_idle: assert property ($rose(resetn) |-> sdaOen && waveOrIrqOen)
      else $error("pins not released out of reset");
   a_sda_scl_low: assert property (!$stable(sdaOen) |-> !sclIn)
      else $error("data changed while bus clock high");
   a_addr_ack: assert property (ackMatch |-> ##[1:8] !sdaOen)
      else $error("own address not acknowledged");
   a_addr_nack: assert property (ackMiss |-> sdaOen [*8])
      else $error("foreign address acknowledged");
   a_stop_quiet: assert property (stopEv |-> sdaOen [*8])
      else $error("data driven after stop");
   a_start_quiet: assert property (startEv |-> sdaOen [*8])
      else $error("data driven after start");
endmodule // swr_core_properties
bind swr_core swr_core_properties #(.DEV_ADDR(DEV_ADDR), .PULSE_LEN(PULSE_LEN)) u_props (
   .clock(clock), .resetn(resetn), .crystalIn(crystalIn), .watchdogStrobeIn(watchdogStrobeIn),
   .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOen(sdaOen),
   .waveOrIrqOut(waveOrIrqOut), .waveOrIrqOen(waveOrIrqOen));

/* sim/swr_host_model.sv */
// Two-wire bus controller model; makes the bus clock at 160 ns a bit.
// Assumes the bench clock; the data wire has a pull-up.
`timescale 1ns/100ps
module swr_host_model (
   input wire logic clock,
   input wire logic sdaOen,
   output logic sclIn,
   output logic sdaIn
);
   // ****************************************
   // Wire and frame tasks
   // ****************************************
   logic sdaDrv = 1'b1;
   initial sclIn = 1'b1;
   assign sdaIn = sdaDrv & sdaOen;
   // Quarter bit, changes on falling clock edge
   task automatic q();
      repeat (10) @(negedge clock);
   endtask
   // Start, also usable as repeated start
   task automatic startC();
      sdaDrv = 1'b1;
      q();
      sclIn = 1'b1;
      q();
      sdaDrv = 1'b0;
      q();
      sclIn = 1'b0;
   endtask
   // Nine bits, MSB first, sampled mid-high
   task automatic xfer(input logic [8:0] d, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sdaDrv = d[i];
         q();
         sclIn = 1'b1;
         q();
         rx[i] = sdaIn;
         q();
         sclIn = 1'b0;
         q();
      end
   endtask
   // Stop, bus clock then stands high
   task automatic stopC();
      sdaDrv = 1'b0;
      q();
      sclIn = 1'b1;
      q();
      sdaDrv = 1'b1;
      q();
   endtask
endmodule // swr_host_model

/* sim/swr_core_tb_top.sv */
// Self-checking bench of the core with a register model in integers.
// Assumes the host model and the bound checker are compiled before.
`timescale 1ns/100ps
module swr_core_tb_top import swr_pkg::*; ();
   // ****************************************
   // Clocks, core and bus host
   // ****************************************
   localparam int PLEN = 16;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic crystalIn = 1'b0;
   logic watchdogStrobeIn = 1'b0;
   logic sclIn, sdaIn, sdaOut, sdaOen, waveOrIrqOut, waveOrIrqOen;
   int miscompares = 0;
   int samplesChecked = 0;
   int mdl [9];
   logic [7:0] txq [$];
   logic [7:0] rxq [$];
   logic [8:0] r;
   int lowCnt;
   initial forever #2 clock = ~clock;
   initial forever #100 crystalIn = ~crystalIn;
   swr_core #(.PULSE_LEN(PLEN)) DUT (.clock(clock), .resetn(resetn), .crystalIn(crystalIn),
      .watchdogStrobeIn(watchdogStrobeIn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
      .sdaOen(sdaOen), .waveOrIrqOut(waveOrIrqOut), .waveOrIrqOen(waveOrIrqOen));
   swr_host_model host (.clock(clock), .sdaOen(sdaOen), .sclIn(sclIn), .sdaIn(sdaIn));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Address, pointer and queued bytes; model follows
   task automatic wr(input logic [3:0] p);
      int a;
      host.startC();
      host.xfer({DEV_ADDR_DEF, 2'b01}, r);
      check("addr ack", {7'h0, r[0]}, 8'h00);
      host.xfer({4'h0, p, 1'b1}, r);
      check("ptr ack", {7'h0, r[0]}, 8'h00);
      foreach (txq[i]) begin
         host.xfer({txq[i], 1'b1}, r);
         check("data ack", {7'h0, r[0]}, 8'h00);
         a = (int'(p) + i) % 9;
         if (a == 7) mdl[7] = txq[i] & 8'hef;
         else if (a == 8) mdl[8] = mdl[8] & (txq[i] | 8'h7e);
         else mdl[a] = txq[i];
      end
      txq.delete();
   endtask
   task automatic rd(input logic [3:0] p, input int n);
      rxq.delete();
      wr(p);
      host.startC();
      host.xfer({DEV_ADDR_DEF, 2'b11}, r);
      for (int i = 0; i < n; i++) begin
         host.xfer({8'hff, i == n - 1}, r);
         rxq.push_back(r[8:1]);
      end
      host.stopC();
   endtask
   task automatic rdChk(input logic [3:0] p, input int n);
      rd(p, n);
      foreach (rxq[i]) check("register", rxq[i], 8'(mdl[(int'(p) + i) % 9]));
   endtask
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      void'($urandom(32'h27ea));
      mdl = '{0, 0, 0, 0, 0, 0, 0, 8'h06, 8'h80};
      repeat (20) @(negedge clock);
      resetn = 1'b1;
      repeat (4) @(negedge clock);
      // Square wave at crystal rate out of reset
      r[0] = waveOrIrqOen;
      lowCnt = 0;
      repeat (400) begin
         @(negedge clock);
         if (waveOrIrqOen !== r[0]) lowCnt++;
         r[0] = waveOrIrqOen;
      end
      check("wave edges", 8'(lowCnt inside {[15:17]}), 8'h01);
      rdChk(4'h0, 10);
      host.startC();
      host.xfer({~DEV_ADDR_DEF, 2'b01}, r);
      check("foreign addr", {7'h0, r[0]}, 8'h01);
      host.stopC();
      // Full random write across the wrap
      for (int i = 0; i < 10; i++) txq.push_back(8'($urandom()));
      txq[7] = txq[7] & 8'h2f;
      txq[8] = 8'h00;
      wr(4'h0);
      host.stopC();
      rdChk(4'h0, 9);
      // Alarm pulse in fast mode
      watchdogStrobeIn = 1'b1;
      txq = '{8'h03, 8'h00, 8'h00, 8'h69};
      wr(4'h4);
      host.stopC();
      for (lowCnt = 0; waveOrIrqOen !== 1'b0 && lowCnt < 4000; lowCnt++) @(negedge clock);
      for (lowCnt = 0; waveOrIrqOen === 1'b0 && lowCnt < 4000; lowCnt++) @(negedge clock);
      check("pulse ticks", 8'((lowCnt + 25) / 50), 8'(PLEN));
      mdl[4] = 0;
      rdChk(4'h4, 5);
      txq = '{8'h81};
      wr(4'h8);
      host.stopC();
      rdChk(4'h8, 1);
      // Steady strobe, then a rising edge
      txq = '{8'hc8, 8'h00, 8'h00};
      wr(4'h4);
      host.stopC();
      repeat (5000) @(negedge clock);
      rd(4'h4, 1);
      check("running", 8'(rxq[0] inside {[8'hb4:8'hbe]}), 8'h01);
      watchdogStrobeIn = 1'b0;
      repeat (10) @(negedge clock);
      watchdogStrobeIn = 1'b1;
      rd(4'h4, 1);
      check("reloaded", 8'(rxq[0] inside {[8'hc4:8'hc8]}), 8'h01);
      endOfTest();
   end
   // Watchdog on a hung run
   initial begin
      repeat (80000) @(negedge clock);
      miscompares++;
      endOfTest();
   end
endmodule // swr_core_tb_top
